// [logic/cpu_compare_clear_bcd_div_ops.sv]
// execution unit for compare-branch, clear, complement, decimal adjust, decrement, divide, loop count
// assumes the core presents opcode, operand bytes and operands with opValid; results return one clock later, or when the divider finishes
`timescale 1ns/1ns
module cpu_compare_clear_bcd_div_ops
  import cpu_ops_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            reset_n,
  input  wire logic            opValid,
  input  wire logic [7:0]      opcode,
  input  wire logic [7:0]      immData,
  input  wire logic [7:0]      relOffset,
  input  wire logic [PC_W-1:0] pcIn,
  input  wire logic [7:0]      accIn,
  input  wire logic [7:0]      bIn,
  input  wire logic            carryIn,
  input  wire logic            auxCarryIn,
  input  wire logic            overflowIn,
  input  wire logic [7:0]      memOperand,
  input  wire logic            operandIsPort,
  input  wire logic [7:0]      portLatch,
  input  wire logic            bitValue,
  input  wire logic            bitIsPort,
  input  wire logic            bitLatch,
  output logic                 busy,
  output logic                 done,
  output logic [PC_W-1:0]      pcOut,
  output logic [7:0]           accOut,
  output logic [7:0]           bOut,
  output logic                 carryOut,
  output logic                 auxCarryOut,
  output logic                 overflowOut,
  output logic                 parityOut,
  output logic [7:0]           memResult,
  output logic                 memWrite,
  output logic                 bitResult,
  output logic                 bitWrite,
  output logic [1:0]           instrLength,
  output logic [1:0]           instrCycles
);
  // ************************************************************
  // decode and combinational results
  // ************************************************************
  op_state_t        state;
  logic [7:0]       srcByte;
  logic             srcBit;
  logic [7:0]       decByte;
  logic [PC_W-1:0]  pcNext3;
  logic [PC_W-1:0]  pcNext2;
  logic [PC_W-1:0]  relExt;
  logic [8:0]       adjLow;
  logic [8:0]       adjHigh;
  logic             adjCarry;
  logic             isCmp;
  logic             isDecMem;
  logic             isDjnz;
  logic             isDjnzDir;
  logic             divStart;
  logic             divDone;
  logic [7:0]       divQuot;
  logic [7:0]       divRem;
  logic             divByZero;
  logic             cmpUnequal;
  logic             loopAgain;

  // ports are byte wide and the offset is sign-extended into the pc, so the pc must be wider than a byte
  if (DATA_W != 8 || PC_W <= 8) begin : g_width_check
    $error("cpu_compare_clear_bcd_div_ops needs 8-bit data and a pc wider than 8 bits");
  end

  assign srcByte   = operandIsPort ? portLatch : memOperand;
  assign srcBit    = bitIsPort ? bitLatch : bitValue;
  assign decByte   = srcByte - ONE_BYTE;
  assign relExt    = {{(PC_W-8){relOffset[7]}}, relOffset};
  assign pcNext3   = pcIn + PC_W'(LEN_3);
  assign pcNext2   = pcIn + PC_W'(LEN_2);
  assign isCmp     = ((opcode & MSK_REG) == OP_CMP_REG) || ((opcode & MSK_IND) == OP_CMP_IND);
  assign isDecMem  = ((opcode & MSK_REG) == OP_DEC_REG) || ((opcode & MSK_IND) == OP_DEC_IND)
                     || (opcode == OP_DEC_DIR);
  assign isDjnzDir = opcode == OP_DECREMENT_BRANCH_NONZERO_DIR;
  assign isDjnz    = ((opcode & MSK_REG) == OP_DECREMENT_BRANCH_NONZERO_REG) || isDjnzDir;
  assign divByZero = bIn == ZERO_BYTE;
  assign divStart  = opValid && (state == ST_IDLE) && (opcode == OP_DIV) && !divByZero;
  assign cmpUnequal = srcByte != immData;
  assign loopAgain  = decByte != ZERO_BYTE;

  always_comb begin
    adjLow = {1'b0, accIn};
    if ((accIn[3:0] > BCD_MAX) || auxCarryIn) begin
      adjLow = {1'b0, accIn} + {5'h00, BCD_FIX};
    end
  end

  // high nibble fix, carry only set
  always_comb begin
    adjHigh = adjLow;
    if ((adjLow[7:4] > BCD_MAX) || adjLow[8] || carryIn) begin
      adjHigh = {1'b0, adjLow[7:0]} + {1'b0, BCD_FIX, 4'h0};
    end
    adjCarry = carryIn | adjLow[8] | adjHigh[8];
  end

  div_unit #(
    .WIDTH(DATA_W)
  ) u_div (
    .clock     (clock),
    .reset_n   (reset_n),
    .start     (divStart),
    .dividend  (accIn),
    .divisor   (bIn),
    .done      (divDone),
    .quotient  (divQuot),
    .remainder (divRem)
  );

  // ************************************************************
  // sequencing
  // ************************************************************
  // divide by a nonzero divisor is multi-cycle; other ops, and divide by zero, finish in the cycle after opValid
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (divStart) begin
            state <= ST_DIV;
            busy  <= 1'b1;
          end
        end
        ST_DIV: begin
          if (divDone) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // result registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      done        <= 1'b0;
      pcOut       <= '0;
      accOut      <= ZERO_BYTE;
      bOut        <= ZERO_BYTE;
      carryOut    <= 1'b0;
      auxCarryOut <= 1'b0;
      overflowOut <= 1'b0;
      memResult   <= ZERO_BYTE;
      memWrite    <= 1'b0;
      bitResult   <= 1'b0;
      bitWrite    <= 1'b0;
      instrLength <= LEN_1;
      instrCycles <= CYC_1;
    end else begin
      done     <= 1'b0;
      memWrite <= 1'b0;
      bitWrite <= 1'b0;
      if (state == ST_DIV) begin
        if (divDone) begin
          done        <= 1'b1;
          accOut      <= divQuot;
          bOut        <= divRem;
          carryOut    <= 1'b0;
          overflowOut <= 1'b0;
        end
      end else if (divStart) begin
        // pcIn may move while the divider runs
        // pc at start
        pcOut       <= pcIn + PC_W'(LEN_1);
        instrLength <= LEN_1;
        auxCarryOut <= auxCarryIn;
      end else if (opValid && !divStart) begin
        done        <= 1'b1;
        pcOut       <= pcIn + PC_W'(LEN_1);
        accOut      <= accIn;
        bOut        <= bIn;
        carryOut    <= carryIn;
        auxCarryOut <= auxCarryIn;
        overflowOut <= overflowIn;
        instrLength <= LEN_1;
        instrCycles <= CYC_1;
        if (isCmp) begin
          instrLength <= LEN_3;
          instrCycles <= CYC_2;
          pcOut       <= cmpUnequal ? pcNext3 + relExt : pcNext3;
          carryOut    <= srcByte < immData;
        end else if (isDjnz) begin
          instrLength <= isDjnzDir ? LEN_3 : LEN_2;
          instrCycles <= CYC_2;
          memResult   <= decByte;
          memWrite    <= 1'b1;
          if (isDjnzDir) begin
            pcOut <= loopAgain ? pcNext3 + relExt : pcNext3;
          end else begin
            pcOut <= loopAgain ? pcNext2 + relExt : pcNext2;
          end
        end else if (isDecMem) begin
          instrLength <= (opcode == OP_DEC_DIR) ? LEN_2 : LEN_1;
          pcOut       <= (opcode == OP_DEC_DIR) ? pcNext2 : pcIn + PC_W'(LEN_1);
          memResult   <= decByte;
          memWrite    <= 1'b1;
        end else begin
          unique case (opcode)
            OP_CLR_ACC: accOut   <= ZERO_BYTE;
            OP_CPL_ACC: accOut   <= ~accIn;
            OP_DEC_ACC: accOut   <= accIn - ONE_BYTE;
            OP_CLR_CY:  carryOut <= 1'b0;
            OP_CPL_CY:  carryOut <= ~carryIn;
            OP_CLR_BIT: begin
              instrLength <= LEN_2;
              pcOut       <= pcNext2;
              bitResult   <= 1'b0;
              bitWrite    <= 1'b1;
            end
            OP_CPL_BIT: begin
              instrLength <= LEN_2;
              pcOut       <= pcNext2;
              bitResult   <= ~srcBit;
              bitWrite    <= 1'b1;
            end
            OP_DADJ: begin
              accOut   <= adjHigh[7:0];
              carryOut <= adjCarry;
            end
            OP_DIV: begin
              accOut      <= DIV0_QUOT;
              bOut        <= DIV0_REM;
              carryOut    <= 1'b0;
              overflowOut <= 1'b1;
            end
            default: begin
              pcOut <= pcIn + PC_W'(LEN_1);
            end
          endcase
        end
      end
    end
  end

  // ************************************************************
  // parity
  // ************************************************************
  // parity of accumulator
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      parityOut <= 1'b0;
    end else if (opValid && !divStart && state == ST_IDLE) begin
      unique case (opcode)
        OP_CLR_ACC: parityOut <= 1'b0;
        OP_CPL_ACC: parityOut <= ^(~accIn);
        OP_DEC_ACC: parityOut <= ^(accIn - ONE_BYTE);
        OP_DADJ:    parityOut <= ^adjHigh[7:0];
        OP_DIV:     parityOut <= ^DIV0_QUOT;
        default:    parityOut <= ^accIn;
      endcase
    end else if (state == ST_DIV && divDone) begin
      parityOut <= ^divQuot;
    end
  end
endmodule

// [logic/cpu_ops_pkg.sv]
// package for the compare, clear, complement, decimal adjust, decrement, divide and loop-count unit
// assumes a core that fetches instruction bytes and owns memory; widths fixed at 8-bit data, 16-bit pc
package cpu_ops_pkg;
  localparam int          DATA_W      = 8;
  localparam int          PC_W        = 16;
  // opcode patterns and masks
  localparam logic [7:0]  OP_CMP_REG  = 8'hB8;
  localparam logic [7:0]  MSK_REG     = 8'hF8;
  localparam logic [7:0]  OP_CMP_IND  = 8'hB6;
  localparam logic [7:0]  MSK_IND     = 8'hFE;
  localparam logic [7:0]  OP_CLR_ACC  = 8'hE4;
  localparam logic [7:0]  OP_CLR_CY   = 8'hC3;
  localparam logic [7:0]  OP_CLR_BIT  = 8'hC2;
  localparam logic [7:0]  OP_CPL_ACC  = 8'hF4;
  localparam logic [7:0]  OP_CPL_CY   = 8'hB3;
  localparam logic [7:0]  OP_CPL_BIT  = 8'hB2;
  localparam logic [7:0]  OP_DADJ     = 8'hD4;
  localparam logic [7:0]  OP_DEC_ACC  = 8'h14;
  localparam logic [7:0]  OP_DEC_REG  = 8'h18;
  localparam logic [7:0]  OP_DEC_DIR  = 8'h15;
  localparam logic [7:0]  OP_DEC_IND  = 8'h16;
  localparam logic [7:0]  OP_DIV      = 8'h84;
  localparam logic [7:0]  OP_DECREMENT_BRANCH_NONZERO_REG = 8'hD8;
  localparam logic [7:0]  OP_DECREMENT_BRANCH_NONZERO_DIR = 8'hD5;
  // lengths and cycle counts
  localparam logic [1:0]  LEN_1       = 2'h1;
  localparam logic [1:0]  LEN_2       = 2'h2;
  localparam logic [1:0]  LEN_3       = 2'h3;
  localparam logic [1:0]  CYC_1       = 2'h1;
  localparam logic [1:0]  CYC_2       = 2'h2;
  // decimal adjust
  localparam logic [3:0]  BCD_MAX     = 4'h9;
  localparam logic [3:0]  BCD_FIX     = 4'h6;
  // fixed results for a zero divisor
  localparam logic [7:0]  DIV0_QUOT   = 8'hFF;
  localparam logic [7:0]  DIV0_REM    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  ONE_BYTE    = 8'h01;
  localparam int          DIV_STEPS   = 8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b10
  } op_state_t;
endpackage

// [logic/div_unit.sv]
// restoring unsigned divider, one quotient bit per clock
// assumes start is a one-cycle pulse from the same clock and operands stay stable only at start
`timescale 1ns/1ns
module div_unit
  import cpu_ops_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] dividend,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  done,
  output logic      [WIDTH-1:0] quotient,
  output logic      [WIDTH-1:0] remainder
);
  // count is five bits wide and the shift needs at least two bits
  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("div_unit WIDTH out of range");
  end

  logic [WIDTH-1:0] dvsr;
  logic [4:0]       count;
  logic             busy;
  logic [WIDTH:0]   trial;

  // shift the next dividend bit into the partial remainder and test it
  always_comb begin
    trial = {remainder, quotient[WIDTH-1]} - {1'b0, dvsr};
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      count     <= 5'h00;
      dvsr      <= '0;
      quotient  <= '0;
      remainder <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy      <= 1'b1;
        count     <= 5'(WIDTH);
        dvsr      <= divisor;
        quotient  <= dividend;
        remainder <= '0;
      end else if (busy) begin
        if (!trial[WIDTH]) begin
          remainder <= trial[WIDTH-1:0];
        end else begin
          remainder <= {remainder[WIDTH-2:0], quotient[WIDTH-1]};
        end
        quotient <= {quotient[WIDTH-2:0], ~trial[WIDTH]};
        count    <= count - 5'h01;
        if (count == 5'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// [verif/cpu_ops_props.sv]
// checker for the execution unit, watching only the top ports
// assumes binding from the bench top and the package constants
`timescale 1ns/1ns
module cpu_ops_props
  import cpu_ops_pkg::*;
(
  input wire logic            clock,
  input wire logic            reset_n,
  input wire logic            opValid,
  input wire logic [7:0]      opcode,
  input wire logic [7:0]      immData,
  input wire logic [7:0]      relOffset,
  input wire logic [PC_W-1:0] pcIn,
  input wire logic [7:0]      accIn,
  input wire logic [7:0]      bIn,
  input wire logic            carryIn,
  input wire logic            overflowIn,
  input wire logic [7:0]      memOperand,
  input wire logic            operandIsPort,
  input wire logic [7:0]      portLatch,
  input wire logic            busy,
  input wire logic            done,
  input wire logic [PC_W-1:0] pcOut,
  input wire logic [7:0]      accOut,
  input wire logic [7:0]      bOut,
  input wire logic            carryOut,
  input wire logic            overflowOut,
  input wire logic            parityOut,
  input wire logic [7:0]      memResult,
  input wire logic            memWrite
);
  logic        take;
  logic [15:0] relExt;
  assign take   = opValid && !busy;
  assign relExt = {{8{relOffset[7]}}, relOffset};
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ****************
  // divider timing and per-opcode result checks
  // ****************
  sequence divWait;
    (busy && !done)[*8] ##1 (busy && !done);
  endsequence
  AST_CMP_REG: assert property (take && (opcode & MSK_REG) == OP_CMP_REG |=>
    carryOut == ($past(memOperand) < $past(immData)) && pcOut == $past(pcIn) + 16'h0003
    + (($past(memOperand) != $past(immData)) ? $past(relExt) : 16'h0000)) else $error("compare result wrong");
  AST_CLR_ACC: assert property (take && opcode == OP_CLR_ACC |=>
    done && accOut == ZERO_BYTE && carryOut == $past(carryIn)) else $error("clear accumulator wrong");
  AST_CPL_ACC: assert property (take && opcode == OP_CPL_ACC |=>
    accOut == ~$past(accIn) && overflowOut == $past(overflowIn)) else $error("complement accumulator wrong");
  AST_DEC_PORT: assert property (take && opcode == OP_DEC_DIR && operandIsPort |=>
    memWrite && memResult == $past(portLatch) - ONE_BYTE) else $error("port decrement not from latch");
  AST_DADJ_CARRY: assert property (take && opcode == OP_DADJ && carryIn |=>
    carryOut && overflowOut == $past(overflowIn)) else $error("decimal adjust cleared carry");
  AST_DIV_RUN: assert property (take && opcode == OP_DIV && bIn != ZERO_BYTE |=>
    divWait ##1 (done && !busy && !carryOut && !overflowOut)) else $error("divide timing or flags wrong");
  AST_DIV_ZERO: assert property (take && opcode == OP_DIV && bIn == ZERO_BYTE |=> done && overflowOut
    && !carryOut && accOut == DIV0_QUOT && bOut == DIV0_REM) else $error("zero divisor result wrong");
  AST_DECREMENT_BRANCH_NONZERO: assert property (take && (opcode & MSK_REG) == OP_DECREMENT_BRANCH_NONZERO_REG |=> memWrite
    && memResult == $past(memOperand) - ONE_BYTE && pcOut == $past(pcIn) + 16'h0002
    + (($past(memOperand) != ONE_BYTE) ? $past(relExt) : 16'h0000)) else $error("loop count wrong");
  AST_PARITY: assert property (done |-> parityOut == ^accOut) else $error("parity wrong");
endmodule

// [verif/testbench.sv]
// self-checking bench for the execution unit
// assumes the checker file is compiled before this one
`timescale 1ns/1ns
module testbench
  import cpu_ops_pkg::*;
;
  localparam logic [7:0] NIL = 8'h00;
  logic clock = 1'b0, reset_n = 1'b0, opValid = 1'b0, carryIn = 1'b0, auxCarryIn = 1'b0, overflowIn = 1'b0;
  logic operandIsPort = 1'b0, bitValue = 1'b0, bitIsPort = 1'b0, bitLatch = 1'b0;
  logic [7:0] opcode = 8'h00, immData = 8'h00, relOffset = 8'h00, accIn = 8'h00, bIn = 8'h00;
  logic [7:0] memOperand = 8'h00, portLatch = 8'h00;
  logic [15:0] pcIn = 16'h0000, pcOut;
  logic busy, done, carryOut, auxCarryOut, overflowOut, parityOut, memWrite, bitResult, bitWrite;
  logic [7:0] accOut, bOut, memResult;
  logic [1:0] instrLength, instrCycles;
  int fails = 0, checks_done = 0, cyc = 0;
  cpu_compare_clear_bcd_div_ops dut (
    .clock(clock), .reset_n(reset_n), .opValid(opValid), .opcode(opcode), .immData(immData),
    .relOffset(relOffset), .pcIn(pcIn), .accIn(accIn), .bIn(bIn), .carryIn(carryIn), .auxCarryIn(auxCarryIn),
    .overflowIn(overflowIn), .memOperand(memOperand), .operandIsPort(operandIsPort), .portLatch(portLatch),
    .bitValue(bitValue), .bitIsPort(bitIsPort), .bitLatch(bitLatch), .busy(busy), .done(done), .pcOut(pcOut),
    .accOut(accOut), .bOut(bOut), .carryOut(carryOut), .auxCarryOut(auxCarryOut), .overflowOut(overflowOut),
    .parityOut(parityOut), .memResult(memResult), .memWrite(memWrite), .bitResult(bitResult),
    .bitWrite(bitWrite), .instrLength(instrLength), .instrCycles(instrCycles)
  );
  always #5 clock = ~clock;
  // ****************
  // shared tasks
  // ****************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // f is carry, aux, overflow; x is port operand, pin bit, port bit, latch bit
  task automatic issue(logic [7:0] op, imm, rel, a, b, m, logic [2:0] f, logic [3:0] x = 4'h0);
    @(posedge clock);
    opValid <= 1'b1;
    opcode <= op;
    immData <= imm;
    relOffset <= rel;
    accIn <= a;
    bIn <= b;
    memOperand <= m;
    portLatch <= ~m;
    pcIn <= {8'h01, a};
    {carryIn, auxCarryIn, overflowIn} <= f;
    {operandIsPort, bitValue, bitIsPort, bitLatch} <= x;
    @(posedge clock);
    opValid <= 1'b0;
    // done stands one cycle only: look just after the taking edge before waiting on
    #1;
    for (int i = 0; i < 12 && done !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk("done", 16'h0001, done);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_cmp;
    logic [7:0] m [4] = '{8'h60, 8'h34, 8'h80, 8'h60};
    for (int i = 0; i < 4; i++) begin
      issue(i[0] ? OP_CMP_IND | 8'h01 : OP_CMP_REG | 8'h07, 8'h60, 8'hF0, 8'h00, 8'h00, m[i], 3'b100);
      chk("cmp pc", (m[i] == 8'h60) ? 16'h0103 : 16'h00F3, pcOut);
      chk("cmp carry", m[i] < 8'h60, carryOut);
      chk("cmp size", {LEN_3, CYC_2}, {instrLength, instrCycles});
    end
    $display("test compare finished");
  endtask
  task automatic t_clr_cpl;
    issue(OP_CLR_ACC, NIL, NIL, 8'h5C, NIL, NIL, 3'b111);
    chk("clr acc", 16'h0000, accOut);
    chk("clr flags", 3'b111, {carryOut, auxCarryOut, overflowOut});
    issue(OP_CPL_ACC, NIL, NIL, 8'h5D, NIL, NIL, 3'b101);
    chk("cpl acc", 16'h00A2, accOut);
    chk("cpl flags", 3'b101, {carryOut, auxCarryOut, overflowOut});
    chk("cpl parity", 16'h0001, parityOut);
    issue(OP_CLR_CY, NIL, NIL, 8'h00, NIL, NIL, 3'b101);
    chk("clr carry", {2'b01, LEN_1}, {carryOut, overflowOut, instrLength});
    issue(OP_CPL_CY, NIL, NIL, 8'h00, NIL, NIL, 3'b001);
    chk("cpl carry", 2'b11, {carryOut, overflowOut});
    issue(OP_CLR_BIT, NIL, NIL, 8'h00, NIL, NIL, 3'b000, 4'b0111);
    chk("clr bit", {2'b01, LEN_2}, {bitResult, bitWrite, instrLength});
    issue(OP_CPL_BIT, NIL, NIL, 8'h00, NIL, NIL, 3'b000, 4'b0110);
    chk("cpl bit latch", {2'b11, LEN_2}, {bitResult, bitWrite, instrLength});
    $display("test clear complement finished");
  endtask
  task automatic t_da;
    logic [7:0] a [4] = '{8'hBE, 8'hC9, 8'h12, 8'h56};
    logic [2:0] f [4] = '{3'b001, 3'b000, 3'b100, 3'b010};
    logic [8:0] e [4] = '{9'h124, 9'h129, 9'h172, 9'h05C};
    for (int i = 0; i < 4; i++) begin
      issue(OP_DADJ, NIL, NIL, a[i], NIL, NIL, f[i]);
      chk("da result", e[i], {carryOut, accOut});
      chk("da ov", f[i][0], overflowOut);
    end
    $display("test decimal adjust finished");
  endtask
  task automatic t_dec;
    issue(OP_DEC_ACC, NIL, NIL, 8'h00, NIL, NIL, 3'b111);
    chk("dec acc", 16'h00FF, accOut);
    chk("dec flags", {3'b111, LEN_1, CYC_1}, {carryOut, auxCarryOut, overflowOut, instrLength, instrCycles});
    chk("dec parity", 16'h0000, parityOut);
    issue(OP_DEC_REG | 8'h03, NIL, NIL, NIL, NIL, 8'h7F, 3'b000);
    chk("dec reg", 16'h017E, {memWrite, memResult});
    issue(OP_DEC_DIR, NIL, NIL, NIL, NIL, 8'h55, 3'b000, 4'b1000);
    chk("dec port", 16'h01A9, {memWrite, memResult});
    chk("dec dir size", {LEN_2, CYC_1}, {instrLength, instrCycles});
    issue(OP_DEC_IND | 8'h01, NIL, NIL, NIL, NIL, 8'h00, 3'b000);
    chk("dec ind", 16'h01FF, {memWrite, memResult});
    $display("test decrement finished");
  endtask
  task automatic t_div;
    issue(OP_DIV, NIL, NIL, 8'hFB, 8'h12, NIL, 3'b101);
    chk("div result", 16'h0D11, {accOut, bOut});
    chk("div flags", 16'h0000, {carryOut, overflowOut});
    chk("div pc", 16'h01FC, pcOut);
    issue(OP_DIV, NIL, NIL, 8'h07, 8'h00, NIL, 3'b100);
    chk("div zero", {DIV0_QUOT, DIV0_REM}, {accOut, bOut});
    chk("div zero flags", 2'b01, {carryOut, overflowOut});
    issue(OP_DIV, NIL, NIL, 8'h00, 8'hFF, NIL, 3'b000);
    chk("div small", 16'h0000, {accOut, bOut});
    $display("test divide finished");
  endtask
  task automatic t_decrement_branch_nonzero;
    issue(OP_DECREMENT_BRANCH_NONZERO_REG | 8'h02, NIL, 8'h10, 8'h40, NIL, 8'h01, 3'b111);
    chk("decrement_branch_nonzero last", 16'h0100, {memWrite, memResult});
    chk("decrement_branch_nonzero pc", 16'h0142, pcOut);
    chk("decrement_branch_nonzero flags", 3'b111, {carryOut, auxCarryOut, overflowOut});
    issue(OP_DECREMENT_BRANCH_NONZERO_DIR, NIL, 8'hFC, 8'h40, NIL, 8'h00, 3'b000);
    chk("decrement_branch_nonzero wrap", 16'h01FF, {memWrite, memResult});
    chk("decrement_branch_nonzero branch", 16'h013F, pcOut);
    $display("test loop count finished");
  endtask
  // ****************
  // run control
  // ****************
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk("reset size", {LEN_1, CYC_1}, {instrLength, instrCycles});
    chk("reset done", 16'h0000, done);
    t_cmp();
    t_clr_cpl();
    t_da();
    t_dec();
    t_div();
    t_decrement_branch_nonzero();
    report_and_stop();
  end
endmodule
bind cpu_compare_clear_bcd_div_ops cpu_ops_props props (
  .clock(clock), .reset_n(reset_n), .opValid(opValid), .opcode(opcode), .immData(immData),
  .relOffset(relOffset), .pcIn(pcIn), .accIn(accIn), .bIn(bIn), .carryIn(carryIn), .overflowIn(overflowIn),
  .memOperand(memOperand), .operandIsPort(operandIsPort), .portLatch(portLatch), .busy(busy), .done(done),
  .pcOut(pcOut), .accOut(accOut), .bOut(bOut), .carryOut(carryOut), .overflowOut(overflowOut),
  .parityOut(parityOut), .memResult(memResult), .memWrite(memWrite)
);
